// File: hw/css_consts.svh
// Overview of operation
// - Among eligible requesters of one level, the lowest channel number wins.
// - A re-requesting served channel waits until its level's other requesters are served.
// - Each channel has request and grant latches; a request sets the request latch.
// - On grant, the grant latch sets and the request latch clears.
// - Grant latches clear only as a whole level, starting a new cycle.
// - Level group clears after its channel is served and no eligible requester remains.
// - With an eligible requester left, the group stays and it is served later.
// - The group check also runs when service came through a passed slot.
// - A group clear costs a four-clock idle with no channel served.
// - Parameter RAM is owned by one side at a time; the other waits.
// - A parameter RAM collision stalls the loser for at most two clocks.
// - Every slot is followed by a ten-clock slot transition.
// - Slots follow the repeating high, middle, high, low, high, middle, high order.
// - Empty slot level passes: H to M then L, M to H then L, L to H then M.
// - With no request anywhere, the scheduler waits at the current slot.
// - One function state runs per slot, ending when the engine reports done.
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

`define CSS_CHANNELS      16
`define CSS_SEQ_LEN       3'h7
`define CSS_NOP_CLKS      4'h4
`define CSS_TRANS_CLKS    4'ha
`define CSS_RAM_CLKS      2'h2

`define CSS_LVL_NONE      2'h0
`define CSS_LVL_LOW       2'h1
`define CSS_LVL_MID       2'h2
`define CSS_LVL_HIGH      2'h3

`define CSS_OFF_PRIO      32'h0000_0000
`define CSS_OFF_LATCH     32'h0000_0004
`define CSS_OFF_STATUS    32'h0000_0008
`define CSS_OFF_CTRL      32'h0000_000c
`define CSS_OFF_COUNT     32'h0000_0010

`define CSS_RST_PRIO      32'h0000_0000
`define CSS_RST_CTRL      1'h1

`define CSS_ST_PTR_LSB    0
`define CSS_ST_PHASE_LSB  4
`define CSS_ST_CHAN_LSB   8
`define CSS_ST_LVL_LSB    12
`define CSS_ST_VALID_BIT  14

`endif

// File: hw/css_pkg.sv
package css_pkg;

	typedef enum logic [1:0]
	{
		CSS_IDLE  = 2'b00,
		CSS_SERVE = 2'b01,
		CSS_NOP   = 2'b10,
		CSS_TRANS = 2'b11
	} css_phase_t;

	typedef enum logic [1:0]
	{
		CSS_OWN_NONE = 2'b00,
		CSS_OWN_ENG  = 2'b01,
		CSS_OWN_CPU  = 2'b10
	} css_owner_t;

	typedef struct packed
	{
		logic       valid;
		logic [3:0] channel;
		logic [1:0] level;
	} css_grant_t;

	typedef struct packed
	{
		logic engine;
		logic cpu;
	} css_ram_pair_t;

	typedef struct packed
	{
		css_owner_t owner;
		logic [1:0] count;
		logic       lastEng;
		css_ram_pair_t gnt;
	} css_arb_state_t;

	typedef struct packed
	{
		css_phase_t  phase;
		logic [3:0]  count;
		logic [2:0]  slotPtr;
		logic [15:0] reqLatch;
		logic [15:0] gntLatch;
		css_grant_t  grant;
		logic        nopActive;
		logic        transActive;
		logic [31:0] prio;
		logic        enable;
		logic [31:0] slotCount;
		logic        wrPend;
		logic [31:0] wrAddr;
		logic [31:0] hrdata;
		logic        hreadyout;
	} css_state_t;

endpackage

// File: hw/css_ram_arbiter.sv
`timescale 1ns/1ps
`include "css_consts.svh"

module css_ram_arbiter
(
	input  wire logic                    clock,
	input  wire logic                    rst_b,
	input  wire css_pkg::css_ram_pair_t  ramReq,
	output      css_pkg::css_ram_pair_t  ramGnt
);

	css_pkg::css_arb_state_t st;
	css_pkg::css_arb_state_t next_st;

	// ****************************************
	// Ownership
	// ****************************************
	// Each access owns the RAM for a fixed two clocks, so a loser never
	// waits longer than that; the side served last yields on a tie.
	always_comb
	begin
		next_st = st;
		if (st.owner != css_pkg::CSS_OWN_NONE && st.count != 2'h0)
		begin
			next_st.count = st.count - 2'h1;
		end
		else
		begin
			next_st.owner = css_pkg::CSS_OWN_NONE;
			if (ramReq.engine && (!ramReq.cpu || !st.lastEng || st.owner == css_pkg::CSS_OWN_CPU))
			begin
				next_st.owner = css_pkg::CSS_OWN_ENG;
				next_st.lastEng = 1'b1;
				next_st.count = `CSS_RAM_CLKS - 2'h1;
			end
			else if (ramReq.cpu)
			begin
				next_st.owner = css_pkg::CSS_OWN_CPU;
				next_st.lastEng = 1'b0;
				next_st.count = `CSS_RAM_CLKS - 2'h1;
			end
		end
		next_st.gnt.engine = (next_st.owner == css_pkg::CSS_OWN_ENG);
		next_st.gnt.cpu = (next_st.owner == css_pkg::CSS_OWN_CPU);
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign ramGnt = st.gnt;

endmodule

// File: hw/css_scheduler.sv
// The AHB-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "css_consts.svh"

module css_scheduler
(
	input  wire logic                    clock,
	input  wire logic                    rst_b,
	// AHB-Lite slave
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output      logic                    hreadyout,
	output      logic [31:0]             hrdata,
	output      logic                    hresp,
	// Channels and execution engine
	input  wire logic [15:0]             chanReq,
	input  wire logic                    engineDone,
	output      css_pkg::css_grant_t     grant,
	output      logic                    nopActive,
	output      logic                    transActive,
	// Parameter RAM access
	input  wire css_pkg::css_ram_pair_t  ramReq,
	output      css_pkg::css_ram_pair_t  ramGnt
);

	css_pkg::css_state_t st;
	css_pkg::css_state_t next_st;

	// ****************************************
	// Helper functions
	// ****************************************
	function automatic logic [1:0] slotLevel(input logic [2:0] ptr);
		logic [1:0] lvl;
		lvl = `CSS_LVL_HIGH;
		case (ptr)
			3'h1: lvl = `CSS_LVL_MID;
			3'h3: lvl = `CSS_LVL_LOW;
			3'h5: lvl = `CSS_LVL_MID;
			default: lvl = `CSS_LVL_HIGH;
		endcase
		return lvl;
	endfunction

	function automatic logic [15:0] levelMask(input logic [31:0] prio, input logic [1:0] lvl);
		logic [15:0] m;
		m = '0;
		for (int i = 0; i < `CSS_CHANNELS; i++)
		begin
			m[i] = (prio[2*i +: 2] == lvl) && (lvl != `CSS_LVL_NONE);
		end
		return m;
	endfunction

	// Eligible means request latch set while grant latch is still clear
	function automatic logic [15:0] eligibleOf(input logic [15:0] req, input logic [15:0] gnt,
		input logic [31:0] prio, input logic [1:0] lvl);
		return req & ~gnt & levelMask(prio, lvl);
	endfunction

	function automatic logic [4:0] lowestOf(input logic [15:0] vec);
		logic [4:0] r;
		r = '0;
		for (int i = `CSS_CHANNELS - 1; i >= 0; i--)
		begin
			if (vec[i])
			begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] passLevel(input logic [1:0] slot, input logic [1:0] rank);
		logic [1:0] lvl;
		lvl = slot;
		if (rank == 2'h1)
		begin
			lvl = (slot == `CSS_LVL_HIGH) ? `CSS_LVL_MID : `CSS_LVL_HIGH;
		end
		else if (rank == 2'h2)
		begin
			lvl = (slot == `CSS_LVL_LOW) ? `CSS_LVL_MID : `CSS_LVL_LOW;
		end
		return lvl;
	endfunction

	// ****************************************
	// Combinational next state
	// ****************************************
	logic [15:0] pick;
	logic [1:0]  pickLvl;
	logic [4:0]  pickIdx;
	logic [15:0] stillEligible;
	logic [15:0] groupMask;
	logic        addrPhase;
	logic [31:0] readWord;

	always_comb
	begin
		next_st = st;
		pick = '0;
		pickLvl = `CSS_LVL_NONE;
		pickIdx = '0;
		stillEligible = '0;
		groupMask = '0;
		readWord = '0;
		next_st.nopActive = 1'b0;
		next_st.transActive = 1'b0;

		// Requests latch regardless of phase; the set is applied after any
		// clear below so a request landing in a grant cycle is not lost.
		case (st.phase)
			css_pkg::CSS_IDLE:
			begin
				for (int r = 2; r >= 0; r--)
				begin
					if (eligibleOf(st.reqLatch, st.gntLatch, st.prio,
						passLevel(slotLevel(st.slotPtr), 2'(r))) != 16'h0)
					begin
						pickLvl = passLevel(slotLevel(st.slotPtr), 2'(r));
					end
				end
				pick = eligibleOf(st.reqLatch, st.gntLatch, st.prio, pickLvl);
				pickIdx = lowestOf(pick);
				// Nothing eligible anywhere: hold the slot pointer and wait
				if (pickIdx[4] && st.enable)
				begin
					next_st.grant.valid = 1'b1;
					next_st.grant.channel = pickIdx[3:0];
					next_st.grant.level = pickLvl;
					next_st.gntLatch[pickIdx[3:0]] = 1'b1;
					next_st.reqLatch[pickIdx[3:0]] = 1'b0;
					next_st.phase = css_pkg::CSS_SERVE;
				end
			end

			css_pkg::CSS_SERVE:
			begin
				if (engineDone)
				begin
					next_st.grant.valid = 1'b0;
					next_st.slotCount = st.slotCount + 32'h1;
					next_st.slotPtr = (st.slotPtr == `CSS_SEQ_LEN - 3'h1) ? 3'h0 : st.slotPtr + 3'h1;
					// Check uses the served channel's own level, even in a passed slot
					stillEligible = eligibleOf(st.reqLatch, st.gntLatch, st.prio, st.grant.level);
					if (stillEligible == 16'h0)
					begin
						groupMask = levelMask(st.prio, st.grant.level);
						next_st.gntLatch = st.gntLatch & ~groupMask;
						next_st.phase = css_pkg::CSS_NOP;
						next_st.count = `CSS_NOP_CLKS - 4'h1;
						next_st.nopActive = 1'b1;
					end
					else
					begin
						next_st.phase = css_pkg::CSS_TRANS;
						next_st.count = `CSS_TRANS_CLKS - 4'h1;
						next_st.transActive = 1'b1;
					end
				end
			end

			css_pkg::CSS_NOP:
			begin
				if (st.count == 4'h0)
				begin
					next_st.phase = css_pkg::CSS_TRANS;
					next_st.count = `CSS_TRANS_CLKS - 4'h1;
					next_st.transActive = 1'b1;
				end
				else
				begin
					next_st.count = st.count - 4'h1;
					next_st.nopActive = 1'b1;
				end
			end

			css_pkg::CSS_TRANS:
			begin
				if (st.count == 4'h0)
				begin
					next_st.phase = css_pkg::CSS_IDLE;
				end
				else
				begin
					next_st.count = st.count - 4'h1;
					next_st.transActive = 1'b1;
				end
			end

			default:
			begin
				next_st.phase = css_pkg::CSS_IDLE;
			end
		endcase

		next_st.reqLatch = next_st.reqLatch | chanReq;

		// ****************************************
		// AHB-Lite slave, zero wait states
		// ****************************************
		addrPhase = hsel && htrans[1] && hready;
		if (st.wrPend)
		begin
			if (st.wrAddr == `CSS_OFF_PRIO)
			begin
				next_st.prio = hwdata;
			end
			else if (st.wrAddr == `CSS_OFF_CTRL)
			begin
				next_st.enable = hwdata[0];
			end
		end
		next_st.wrPend = addrPhase && hwrite;
		next_st.wrAddr = haddr;

		if (haddr == `CSS_OFF_PRIO)
		begin
			readWord = st.prio;
		end
		else if (haddr == `CSS_OFF_LATCH)
		begin
			readWord = {st.gntLatch, st.reqLatch};
		end
		else if (haddr == `CSS_OFF_STATUS)
		begin
			readWord[`CSS_ST_PTR_LSB +: 3] = st.slotPtr;
			readWord[`CSS_ST_PHASE_LSB +: 2] = st.phase;
			readWord[`CSS_ST_CHAN_LSB +: 4] = st.grant.channel;
			readWord[`CSS_ST_LVL_LSB +: 2] = st.grant.level;
			readWord[`CSS_ST_VALID_BIT] = st.grant.valid;
		end
		else if (haddr == `CSS_OFF_CTRL)
		begin
			readWord = {31'h0, st.enable};
		end
		else if (haddr == `CSS_OFF_COUNT)
		begin
			readWord = st.slotCount;
		end
		else
		begin
			readWord = '0;
		end
		next_st.hrdata = (addrPhase && !hwrite) ? readWord : 32'h0;
		next_st.hreadyout = 1'b1;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st <= '0;
			st.prio <= `CSS_RST_PRIO;
			st.enable <= `CSS_RST_CTRL;
			st.hreadyout <= 1'b1;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign hreadyout = st.hreadyout;
	assign hrdata = st.hrdata;
	assign hresp = 1'b0;
	assign grant = st.grant;
	assign nopActive = st.nopActive;
	assign transActive = st.transActive;

	// Parameter RAM ownership between engine and host
	css_ram_arbiter u_ram_arbiter
	(
		.clock  (clock),
		.rst_b  (rst_b),
		.ramReq (ramReq),
		.ramGnt (ramGnt)
	);

endmodule

// File: testbench/css_engine_model.sv
`timescale 1ns/1ps
// ****************************************
// Channel and engine stand-in
// ****************************************
module css_engine_model
#(
	parameter int STATE_CLKS = 6
)
(
	input  wire logic                clock,
	input  wire logic                rst_b,
	input  wire css_pkg::css_grant_t grant,
	input  wire logic [15:0]         reqVec,
	input  wire logic                ramGntEng,
	output      logic [15:0]         chanReq,
	output      logic                engineDone,
	output      logic                ramReqEng
);
	int cnt;
	// Level requests: a served channel asks again at once
	assign chanReq = reqVec;
	always @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt <= 0;
			engineDone <= 1'b0;
			ramReqEng <= 1'b0;
		end
		else
		begin
			engineDone <= 1'b0;
			if (ramGntEng)
				ramReqEng <= 1'b0;
			else if (grant.valid && cnt == 1)
				ramReqEng <= 1'b1;
			if (grant.valid && !engineDone)
			begin
				cnt <= (cnt == STATE_CLKS) ? 0 : cnt + 1;
				engineDone <= (cnt == STATE_CLKS);
			end
		end
	end
endmodule

// File: testbench/css_scheduler_asserts.sv
`timescale 1ns/1ps
module css_scheduler_asserts
(
	input wire logic                   clock,
	input wire logic                   rst_b,
	input wire logic                   engineDone,
	input wire css_pkg::css_grant_t    grant,
	input wire logic                   nopActive,
	input wire logic                   transActive,
	input wire css_pkg::css_ram_pair_t ramReq,
	input wire css_pkg::css_ram_pair_t ramGnt
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	property p_nop_len;
		$rose(nopActive) |-> nopActive[*4] ##1 (!nopActive && transActive);
	endproperty
	a_nop_len: assert property (p_nop_len) else $error("group clear idle length wrong");
	property p_trans_len;
		$rose(transActive) |-> transActive[*8] ##1 transActive[*2] ##1 !transActive;
	endproperty
	a_trans_len: assert property (p_trans_len) else $error("slot transition length wrong");
	property p_quiet;
		(nopActive || transActive) |-> !grant.valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("grant during idle or transition");
	property p_done_end;
		grant.valid && engineDone |=> !grant.valid && (nopActive || transActive);
	endproperty
	a_done_end: assert property (p_done_end) else $error("slot did not end on done");
	property p_hold;
		grant.valid && !engineDone |=> grant.valid && $stable(grant.channel);
	endproperty
	a_hold: assert property (p_hold) else $error("grant changed inside slot");
	property p_gap;
		$fell(transActive) |-> !grant.valid;
	endproperty
	a_gap: assert property (p_gap) else $error("grant right at transition end");
	property p_excl;
		!(ramGnt.engine && ramGnt.cpu);
	endproperty
	a_excl: assert property (p_excl) else $error("both own parameter ram");
	property p_eng_wait;
		ramReq.engine && !ramGnt.engine |-> ##[1:3] ramGnt.engine;
	endproperty
	a_eng_wait: assert property (p_eng_wait) else $error("engine stall too long");
	property p_cpu_wait;
		ramReq.cpu && !ramGnt.cpu |-> ##[1:3] ramGnt.cpu;
	endproperty
	a_cpu_wait: assert property (p_cpu_wait) else $error("cpu stall too long");
endmodule
bind css_scheduler css_scheduler_asserts chk
(
	.clock(clock),
	.rst_b(rst_b),
	.engineDone(engineDone),
	.grant(grant),
	.nopActive(nopActive),
	.transActive(transActive),
	.ramReq(ramReq),
	.ramGnt(ramGnt)
);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`include "css_consts.svh"
module tb_top;
	logic                   clock, rst_b, hsel, hwrite, hreadyout, engineDone;
	logic                   nopActive, transActive, engR, cpuR, nopPrev, hresp;
	logic [31:0]            haddr, hwdata, hrdata, r, s;
	logic [1:0]             htrans;
	logic [2:0]             hsize;
	logic [15:0]            chanReq, reqVec;
	css_pkg::css_grant_t    grant;
	css_pkg::css_ram_pair_t ramReq, ramGnt;
	logic [5:0]             q[$];
	int                     n_fail, checked, nops, cyc;
	assign ramReq = {engR, cpuR};
	css_scheduler DUT (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .chanReq(chanReq), .engineDone(engineDone), .grant(grant),
		.nopActive(nopActive), .transActive(transActive), .ramReq(ramReq), .ramGnt(ramGnt));
	css_engine_model eng (.clock(clock), .rst_b(rst_b), .grant(grant), .reqVec(reqVec),
		.ramGntEng(ramGnt.engine), .chanReq(chanReq), .engineDone(engineDone), .ramReqEng(engR));
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// ****************************************
	// Monitors, cpu ram traffic, hang guard
	// ****************************************
	always @(posedge clock)
	begin
		if (grant.valid && engineDone)
			q.push_back({grant.level, grant.channel});
		nops += (nopActive && !nopPrev);
		nopPrev = nopActive;
		cpuR <= !rst_b ? 1'b0 : ramGnt.cpu ? 1'b0 : grant.valid ? 1'b1 : cpuR;
		cyc++;
		if (cyc == 6000)
		begin
			n_fail++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		// Read data is taken at the edge that ends the data phase
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	task automatic do_reset();
		rst_b <= 1'b0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
	endtask
	task automatic run(input logic [31:0] p, input logic [15:0] rq, input int n, input logic [31:0] e, input int nn);
		do_reset();
		bus(1'b1, `CSS_OFF_PRIO, p, r);
		q.delete();
		nops = 0;
		reqVec <= rq;
		while (q.size() < n) @(posedge clock);
		reqVec <= 16'h0;
		repeat (2) @(posedge clock);
		for (int i = 0; i < n; i++)
		begin
			chk({28'h0, q[i][3:0]}, {28'h0, e[4*i+:4]});
			chk({30'h0, q[i][5:4]}, {30'h0, p[2*q[i][3:0]+:2]});
		end
		chk(nops, nn);
	endtask
	task automatic complete_run();
		if (n_fail == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		{rst_b, hsel, hwrite, htrans, hsize, haddr, hwdata, reqVec} = '0;
		{n_fail, checked, nops, cyc} = '0;
		hsize = 3'h2;
		do_reset();
		bus(1'b0, `CSS_OFF_PRIO, 32'h0, r);
		chk(r, `CSS_RST_PRIO);
		bus(1'b0, `CSS_OFF_CTRL, 32'h0, r);
		chk(r, {31'h0, `CSS_RST_CTRL});
		bus(1'b1, 32'h20, 32'hffff_ffff, r);
		bus(1'b0, 32'h20, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b1, `CSS_OFF_PRIO, 32'ha5a5_a5a5, r);
		bus(1'b0, `CSS_OFF_PRIO, 32'h0, r);
		chk(r, 32'ha5a5_a5a5);
		bus(1'b1, `CSS_OFF_PRIO, 32'h0, r);
		reqVec <= 16'h0001;
		repeat (30) @(posedge clock);
		bus(1'b0, `CSS_OFF_LATCH, 32'h0, r);
		chk(r, 32'h1);
		chk(q.size(), 0);
		// Disabled scheduler must hold a pending eligible request
		bus(1'b1, `CSS_OFF_CTRL, 32'h0, r);
		bus(1'b1, `CSS_OFF_PRIO, 32'h3, r);
		repeat (30) @(posedge clock);
		chk(q.size(), 0);
		bus(1'b0, `CSS_OFF_CTRL, 32'h0, r);
		chk(r, 32'h0);
		bus(1'b1, `CSS_OFF_CTRL, 32'h1, r);
		repeat (20) @(posedge clock);
		chk(q.size(), 1);
		chk({28'h0, q[0][3:0]}, 32'h0);
		run(32'h000c_0c03, 16'h0221, 6, 32'h0095_0950, 2);
		run(32'h0000_001b, 16'h0007, 8, 32'h0010_2010, 8);
		run(32'h0000_0018, 16'h0006, 7, 32'h0111_2111, 7);
		repeat (100) @(posedge clock);
		bus(1'b0, `CSS_OFF_STATUS, 32'h0, r);
		bus(1'b0, `CSS_OFF_COUNT, 32'h0, s);
		chk({29'h0, r[2:0]}, s % 32'h7);
		repeat (40) @(posedge clock);
		bus(1'b0, `CSS_OFF_STATUS, 32'h0, s);
		chk(s, r);
		complete_run();
	end
endmodule
